// ---- rtl/guard_pkg.sv ----
// Constants and types for the write guard and stop latch block
package guard_pkg;
    localparam int PNUM_W = 10;
    localparam int SET_W = 14;
    localparam logic [SET_W-1:0] NOT_USED = 14'h270f;
    localparam logic [1:0] WP_STOP_ONLY = 2'h0;
    localparam logic [1:0] WP_LOCKED = 2'h1;
    localparam logic [1:0] WP_ANY = 2'h2;
    localparam logic [1:0] DIR_BOTH = 2'h0;
    localparam logic [1:0] DIR_NO_REV = 2'h1;
    localparam logic [1:0] DIR_NO_FWD = 2'h2;
    localparam logic [4:0] RSS_LATCH_MIN = 5'h0e;
    localparam logic [PNUM_W-1:0] P_CARRIER = 10'h048;
    localparam logic [PNUM_W-1:0] P_SOFTMOD = 10'h0f0;
    localparam logic [PNUM_W-1:0] P_WPERM = 10'h04d;
    localparam logic [PNUM_W-1:0] P_DIRINH = 10'h04e;
    typedef enum logic [1:0] {
        SRC_PANEL = 2'b00,
        SRC_HANDHELD = 2'b01,
        SRC_SERIAL = 2'b10,
        SRC_TERMINAL = 2'b11
    } src_t;
    typedef enum logic [1:0] {
        REQ_WRITE = 2'b00,
        REQ_CLEAR = 2'b01,
        REQ_ALL_CLEAR = 2'b10,
        REQ_READ = 2'b11
    } req_t;
endpackage

// ---- rtl/param_write_guard.sv ----
// Write permission gate, direction inhibit and operator stop latch
`timescale 1ns/10ps
module param_write_guard (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic FORWARD_START_INPUT,
    input wire logic REVERSE_START_INPUT,
    input wire logic EXTERNAL_RESET_INPUT,
    input wire logic PANEL_OPERATION,
    input wire logic RUNNING,
    input wire logic HANDHELD_PRESENT,
    input wire logic [guard_pkg::SET_W-1:0] COMMAND_SOURCE_SELECTION,
    input wire logic [4:0] RESET_STOP_SELECTION,
    input wire logic [guard_pkg::SET_W-1:0] STOP_METHOD_SETTING,
    input wire logic [guard_pkg::SET_W-1:0] EXTENDED_DISPLAY_SELECTION,
    input wire logic STOP_KEY_PANEL,
    input wire logic STOP_KEY_HANDHELD,
    input wire logic MODE_KEY,
    input wire logic FORWARD_KEY,
    input wire logic REVERSE_KEY,
    input wire logic SERIAL_FORWARD,
    input wire logic SERIAL_REVERSE,
    input wire logic REQ_VALID,
    input wire guard_pkg::req_t REQ_KIND,
    input wire logic [guard_pkg::PNUM_W-1:0] REQ_PARAM,
    input wire logic [1:0] REQ_DATA,
    input wire logic EXEMPT_GROUP,
    input wire guard_pkg::src_t REQ_SOURCE,
    output logic OPERATOR_STOP_LATCH,
    output logic STOP_DECELERATE,
    output logic RUN_FORWARD,
    output logic RUN_REVERSE,
    output logic [1:0] WRITE_PERMISSION_SETTING,
    output logic [1:0] DIRECTION_INHIBIT_SETTING,
    output logic REQ_DONE,
    output logic REQ_ACCEPTED,
    output logic REQ_REFUSED,
    output logic PARAM_COMMIT,
    output guard_pkg::src_t RESP_SOURCE,
    output logic HANDHELD_IS_SOURCE
);
    import guard_pkg::*;

    // ==============================================================
    // Input synchronisers for pins
    logic [1:0] fwd_s, rev_s, res_s;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fwd_s <= 2'h0;
            rev_s <= 2'h0;
            res_s <= 2'h0;
        end else begin
            fwd_s <= {fwd_s[0], FORWARD_START_INPUT};
            rev_s <= {rev_s[0], REVERSE_START_INPUT};
            res_s <= {res_s[0], EXTERNAL_RESET_INPUT};
        end
    end
    wire fwd_pin = fwd_s[1];
    wire rev_pin = rev_s[1];
    wire ext_res = res_s[1];

    // ==============================================================
    // Command source and stop latch
    wire handheld_sel = HANDHELD_PRESENT
        && (COMMAND_SOURCE_SELECTION == NOT_USED);
    wire latch_on = RESET_STOP_SELECTION >= RSS_LATCH_MIN;
    wire sel_stop = handheld_sel ? STOP_KEY_HANDHELD : STOP_KEY_PANEL;
    wire other_stop = handheld_sel ? STOP_KEY_PANEL : STOP_KEY_HANDHELD;
    wire any_stop = STOP_KEY_PANEL | STOP_KEY_HANDHELD;
    wire set_latch = latch_on && ((!PANEL_OPERATION && any_stop)
        || (PANEL_OPERATION && other_stop));
    wire clr_latch = MODE_KEY && !RUNNING && !fwd_pin && !rev_pin;
    wire latch_d = set_latch ? 1'b1
        : (clr_latch ? 1'b0 : OPERATOR_STOP_LATCH);
    // Decelerate, never coast, regardless of stop method
    wire decel_d = latch_d || (PANEL_OPERATION && sel_stop)
        || (!latch_on && PANEL_OPERATION && any_stop);

    // ==============================================================
    // Direction inhibit over every start source
    wire fwd_req = PANEL_OPERATION ? FORWARD_KEY : (fwd_pin | SERIAL_FORWARD);
    wire rev_req = PANEL_OPERATION ? REVERSE_KEY : (rev_pin | SERIAL_REVERSE);
    wire fwd_ok = DIRECTION_INHIBIT_SETTING != DIR_NO_FWD;
    wire rev_ok = DIRECTION_INHIBIT_SETTING != DIR_NO_REV;
    wire can_run = !latch_d && !decel_d;
    wire run_f_d = can_run && fwd_req && !rev_req && fwd_ok;
    wire run_r_d = can_run && rev_req && !fwd_req && rev_ok;

    // ==============================================================
    // Write permission gate
    function automatic logic run_locked(input logic [PNUM_W-1:0] p);
        int n;
        n = int'(p);
        run_locked = (n == 23) || (n == 40) || (n == 48) || (n == 60)
            || (n == 66) || (n == 71) || (n == 79) || (n == 80)
            || (n >= 82 && n <= 84) || (n == 90) || (n == 96)
            || (n >= 178 && n <= 182) || (n == 190) || (n == 192)
            || (n >= 255 && n <= 258) || (n == 261) || (n == 298)
            || (n == 343) || (n == 450) || (n == 561) || (n == 563)
            || (n == 564);
    endfunction
    function automatic logic lock_exempt(input logic [PNUM_W-1:0] p);
        int n;
        n = int'(p);
        lock_exempt = (n == 22) || (n == 75) || (n == 77) || (n == 79)
            || (n == 160) || (n == 296) || (n == 297);
    endfunction
    wire is_write = REQ_KIND == REQ_WRITE;
    wire is_clear = (REQ_KIND == REQ_CLEAR) || (REQ_KIND == REQ_ALL_CLEAR);
    wire own_param = (REQ_PARAM == P_WPERM) || (REQ_PARAM == P_DIRINH);
    wire panel_run_ok = (REQ_PARAM == P_CARRIER)
        || (REQ_PARAM == P_SOFTMOD);
    wire ok0 = (PANEL_OPERATION && !RUNNING)
        || (EXEMPT_GROUP && !panel_run_ok)
        || (panel_run_ok && PANEL_OPERATION);
    wire ok1 = is_write && lock_exempt(REQ_PARAM);
    wire ok2 = !(RUNNING && run_locked(REQ_PARAM));
    wire wp_ok = (REQ_PARAM == P_WPERM) ? 1'b1
        : (WRITE_PERMISSION_SETTING == WP_STOP_ONLY) ? ok0
        : (WRITE_PERMISSION_SETTING == WP_LOCKED) ? ok1 : ok2;
    wire disp_ok = !own_param || (EXTENDED_DISPLAY_SELECTION == '0);
    wire mod_req = is_write || is_clear;
    wire accept = !mod_req || (wp_ok && disp_ok && !(is_clear
        && WRITE_PERMISSION_SETTING == WP_LOCKED));
    wire commit = REQ_VALID && accept && mod_req;
    wire wr_wp = commit && is_write && (REQ_PARAM == P_WPERM)
        && (REQ_DATA <= WP_ANY);
    wire wr_dir = commit && is_write && (REQ_PARAM == P_DIRINH)
        && (REQ_DATA <= DIR_NO_FWD);

    // ==============================================================
    // Registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            OPERATOR_STOP_LATCH <= 1'b0;
            STOP_DECELERATE <= 1'b0;
            RUN_FORWARD <= 1'b0;
            RUN_REVERSE <= 1'b0;
            WRITE_PERMISSION_SETTING <= WP_STOP_ONLY;
            DIRECTION_INHIBIT_SETTING <= DIR_BOTH;
            REQ_DONE <= 1'b0;
            REQ_ACCEPTED <= 1'b0;
            REQ_REFUSED <= 1'b0;
            PARAM_COMMIT <= 1'b0;
            RESP_SOURCE <= SRC_PANEL;
            HANDHELD_IS_SOURCE <= 1'b0;
        end else begin
            OPERATOR_STOP_LATCH <= ext_res ? 1'b0 : latch_d;
            STOP_DECELERATE <= !ext_res && decel_d;
            RUN_FORWARD <= !ext_res && run_f_d;
            RUN_REVERSE <= !ext_res && run_r_d;
            if (wr_wp) WRITE_PERMISSION_SETTING <= REQ_DATA;
            if (wr_dir) DIRECTION_INHIBIT_SETTING <= REQ_DATA;
            REQ_DONE <= REQ_VALID;
            REQ_ACCEPTED <= REQ_VALID && accept;
            REQ_REFUSED <= REQ_VALID && !accept;
            PARAM_COMMIT <= commit;
            if (REQ_VALID) RESP_SOURCE <= REQ_SOURCE;
            HANDHELD_IS_SOURCE <= handheld_sel;
        end
    end

    // ==============================================================
    // Assertions
    a_latch_reset_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        ext_res |=> !OPERATOR_STOP_LATCH)
        else $error("stop latch not cleared by reset");
    a_latch_sets: assert property (@(posedge CLK) disable iff (!RST_N)
        (set_latch && !ext_res) |=> OPERATOR_STOP_LATCH && STOP_DECELERATE)
        else $error("stop latch not set");
    a_no_latch_low: assert property (@(posedge CLK) disable iff (!RST_N)
        (!latch_on && !OPERATOR_STOP_LATCH) |=> !OPERATOR_STOP_LATCH)
        else $error("latch set while disabled");
    a_dir_rev_block: assert property (@(posedge CLK) disable iff (!RST_N)
        DIRECTION_INHIBIT_SETTING == DIR_NO_REV |=> !RUN_REVERSE)
        else $error("reverse ran while inhibited");
    a_dir_fwd_block: assert property (@(posedge CLK) disable iff (!RST_N)
        DIRECTION_INHIBIT_SETTING == DIR_NO_FWD |=> !RUN_FORWARD)
        else $error("forward ran while inhibited");
    a_lock_refuse: assert property (@(posedge CLK) disable iff (!RST_N)
        (REQ_VALID && is_clear && WRITE_PERMISSION_SETTING == WP_LOCKED)
        |=> REQ_REFUSED && !PARAM_COMMIT)
        else $error("clear accepted while locked");
    a_read_allowed: assert property (@(posedge CLK) disable iff (!RST_N)
        (REQ_VALID && REQ_KIND == REQ_READ) |=> REQ_ACCEPTED)
        else $error("read refused");
    a_stop_only: assert property (@(posedge CLK) disable iff (!RST_N)
        (REQ_VALID && is_write && WRITE_PERMISSION_SETTING == WP_STOP_ONLY
        && RUNNING && !EXEMPT_GROUP && !panel_run_ok
        && REQ_PARAM != P_WPERM) |=> REQ_REFUSED)
        else $error("write accepted while running");
    a_run_list: assert property (@(posedge CLK) disable iff (!RST_N)
        (REQ_VALID && is_write && WRITE_PERMISSION_SETTING == WP_ANY
        && RUNNING && run_locked(REQ_PARAM)) |=> REQ_REFUSED)
        else $error("listed write accepted while running");
    a_wp_stable: assert property (@(posedge CLK) disable iff (!RST_N)
        !wr_wp |=> $stable(WRITE_PERMISSION_SETTING))
        else $error("setting changed without write");
    c_latch: cover property (@(posedge CLK) disable iff (!RST_N)
        set_latch ##1 OPERATOR_STOP_LATCH ##[1:20] !OPERATOR_STOP_LATCH);
    c_refused: cover property (@(posedge CLK) disable iff (!RST_N)
        REQ_REFUSED);
    c_wp_write: cover property (@(posedge CLK) disable iff (!RST_N) wr_wp);
    c_coast_decel: cover property (@(posedge CLK) disable iff (!RST_N)
        (STOP_METHOD_SETTING != NOT_USED && set_latch) ##1 STOP_DECELERATE);
endmodule

// ---- tb/terminal_operator.sv ----
// Operator model that drives the forward start, mode key and reset pins
`timescale 1ns/10ps
module terminal_operator (
    input wire logic CLK,
    input wire logic want_run,
    input wire logic want_rst,
    input wire logic latch,
    input wire logic running,
    output logic start = 1'h0,
    output logic mode_key = 1'h0,
    output logic ext_rst
);
    always @(posedge CLK) begin
        if (!latch)
            start <= want_run;
        else if (start)
            start <= 1'h0;
        mode_key <= latch && !start && !running && !mode_key;
    end
    assign ext_rst = want_rst && !start;
endmodule

// ---- tb/tb_param_write_guard.sv ----
// Self-checking bench for the write guard and stop latch block
`timescale 1ns/10ps
module tb_param_write_guard;
    import guard_pkg::*;
    logic CLK = '0, RST_N = '0, want_run = '0, want_rst = '0, REQ_VALID = '0;
    logic REVERSE_START_INPUT = '0, PANEL_OPERATION = '0, RUNNING = '0;
    logic HANDHELD_PRESENT = '0, STOP_KEY_PANEL = '0, STOP_KEY_HANDHELD = '0;
    logic FORWARD_KEY = '0, REVERSE_KEY = '0, SERIAL_FORWARD = '0;
    logic SERIAL_REVERSE = '0, EXEMPT_GROUP = '0, HANDHELD_IS_SOURCE;
    logic [SET_W-1:0] COMMAND_SOURCE_SELECTION = NOT_USED;
    logic [SET_W-1:0] STOP_METHOD_SETTING = '0, EXTENDED_DISPLAY_SELECTION = '0;
    logic [4:0] RESET_STOP_SELECTION = 5'h0e;
    logic [PNUM_W-1:0] REQ_PARAM = '0, p;
    logic [PNUM_W-1:0] ptab [8] = '{22, 72, 79, 240, 343, 180, 297, 564};
    logic [1:0] REQ_DATA = '0, wp_m = '0, WRITE_PERMISSION_SETTING;
    logic [1:0] DIRECTION_INHIBIT_SETTING;
    req_t REQ_KIND = REQ_READ;
    src_t REQ_SOURCE = SRC_PANEL, RESP_SOURCE;
    logic FORWARD_START_INPUT, MODE_KEY, EXTERNAL_RESET_INPUT, REQ_DONE;
    logic OPERATOR_STOP_LATCH, STOP_DECELERATE, RUN_FORWARD, RUN_REVERSE;
    logic REQ_ACCEPTED, REQ_REFUSED, PARAM_COMMIT;
    int fails = 0, n_tests = 0, seed = 45864, n;
    param_write_guard dut (.*);
    terminal_operator op (.CLK(CLK), .want_run(want_run), .want_rst(want_rst),
        .latch(OPERATOR_STOP_LATCH), .running(RUNNING), .ext_rst(EXTERNAL_RESET_INPUT),
        .start(FORWARD_START_INPUT), .mode_key(MODE_KEY));
    initial begin
        forever #2.5 CLK = ~CLK;
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge CLK);
    endtask
    task automatic try_dir(input logic pnl, forward_key, input int d);
        @(posedge CLK);
        PANEL_OPERATION <= pnl;
        {FORWARD_KEY, REVERSE_KEY} <= {pnl && forward_key, pnl && !forward_key};
        {SERIAL_FORWARD, SERIAL_REVERSE} <= {!pnl && forward_key, !pnl && !forward_key};
        tick(3);
        #1;
        chk({RUN_FORWARD, RUN_REVERSE},
            {forward_key && d != 2, !forward_key && d != 1}, "keys");
    endtask
    function automatic logic busy(input logic [PNUM_W-1:0] q);
        return q inside {23, 40, 48, 60, 66, 71, 79, 80, [82:84], 90, 96,
            [178:182], 190, 192, [255:258], 261, 298, 343, 450, 561, 563, 564};
    endfunction
    function automatic logic exp_ok(req_t k, logic [PNUM_W-1:0] q, logic ex);
        if (q inside {P_WPERM, P_DIRINH} && EXTENDED_DISPLAY_SELECTION != '0)
            return 1'h0;
        if (k == REQ_READ || q == P_WPERM)
            return 1'h1;
        if (wp_m == WP_LOCKED)
            return k == REQ_WRITE && q inside {22, 75, 77, 79, 160, 296, 297};
        if (wp_m == WP_ANY)
            return !(RUNNING && busy(q));
        if (q inside {P_CARRIER, P_SOFTMOD})
            return PANEL_OPERATION;
        if (ex)
            return 1'h1;
        return PANEL_OPERATION && !RUNNING;
    endfunction
    task automatic req(req_t k, logic [PNUM_W-1:0] q, logic [1:0] d, logic ex);
        logic ok;
        src_t s;
        @(posedge CLK);
        ok = exp_ok(k, q, ex);
        s = src_t'(2'($random(seed)));
        REQ_VALID <= 1'h1;
        REQ_KIND <= k;
        REQ_PARAM <= q;
        REQ_DATA <= d;
        EXEMPT_GROUP <= ex;
        REQ_SOURCE <= s;
        @(posedge CLK);
        REQ_VALID <= 1'h0;
        if (ok && k == REQ_WRITE && q == P_WPERM)
            wp_m = d;
        #1;
        chk({REQ_DONE, REQ_ACCEPTED, REQ_REFUSED}, {1'h1, ok, !ok}, "ans");
        chk({PARAM_COMMIT, RESP_SOURCE}, {ok && k != REQ_READ, s}, "cmt");
        chk(WRITE_PERMISSION_SETTING, wp_m, "wperm");
    endtask
    task automatic press_stop(input logic hh);
        @(posedge CLK);
        {STOP_KEY_HANDHELD, STOP_KEY_PANEL} <= {hh, !hh};
        @(posedge CLK);
        {STOP_KEY_HANDHELD, STOP_KEY_PANEL} <= 2'h0;
        #1;
    endtask
    initial begin
        repeat (5000) @(posedge CLK);
        fails++;
        conclude();
    end
    initial begin
        tick(2);
        RST_N <= 1'h1;
        tick(1);
        #1;
        chk({WRITE_PERMISSION_SETTING, DIRECTION_INHIBIT_SETTING,
            OPERATOR_STOP_LATCH, RUN_FORWARD, RUN_REVERSE,
            HANDHELD_IS_SOURCE}, '0, "rst");
        for (int w = 0; w < 3; w++) begin
            req(REQ_WRITE, P_WPERM, w[1:0], 1'h0);
            for (int i = 0; i < 40; i++) begin
                p = ($random(seed) & 1) ? ptab[$random(seed) & 7] : 10'($random(seed));
                if (p inside {P_WPERM, P_DIRINH})
                    p = 10'h016;
                @(posedge CLK);
                RUNNING <= 1'($random(seed));
                PANEL_OPERATION <= 1'($random(seed));
                req(w == 1 ? req_t'(2'($random(seed))) : ($random(seed) & 1 ?
                    REQ_READ : REQ_WRITE), p, 2'h0, ($random(seed) & 1) && !busy(p));
            end
        end
        @(posedge CLK);
        EXTENDED_DISPLAY_SELECTION <= 14'h0001;
        RUNNING <= 1'h0;
        req(REQ_WRITE, P_WPERM, 2'h0, 1'h0);
        req(REQ_WRITE, P_DIRINH, 2'h1, 1'h0);
        @(posedge CLK);
        EXTENDED_DISPLAY_SELECTION <= '0;
        for (int d = 0; d < 3; d++) begin
            req(REQ_WRITE, P_DIRINH, d[1:0], 1'h0);
            chk(DIRECTION_INHIBIT_SETTING, 4'(d), "dir");
            @(posedge CLK);
            PANEL_OPERATION <= 1'h0;
            want_run <= 1'h1;
            tick(6);
            #1;
            chk({RUN_FORWARD, RUN_REVERSE}, {d != 2, 1'h0}, "fwd");
            tick(1);
            want_run <= 1'h0;
            REVERSE_START_INPUT <= 1'h1;
            tick(8);
            #1;
            chk({RUN_FORWARD, RUN_REVERSE}, {1'h0, d != 1}, "rev");
            tick(1);
            REVERSE_START_INPUT <= 1'h0;
            for (int k = 0; k < 4; k++)
                try_dir(k[1], k[0], d);
            tick(1);
            {FORWARD_KEY, SERIAL_FORWARD, REVERSE_KEY, SERIAL_REVERSE} <= '0;
        end
        req(REQ_WRITE, P_DIRINH, 2'h0, 1'h0);
        @(posedge CLK);
        PANEL_OPERATION <= 1'h0;
        RUNNING <= 1'h1;
        want_run <= 1'h1;
        tick(6);
        press_stop(1'h0);
        chk({OPERATOR_STOP_LATCH, STOP_DECELERATE}, 4'h3, "latch");
        tick(4);
        RUNNING <= 1'h0;
        for (n = 0; RUN_FORWARD !== 1'h1 && n < 60; n++)
            tick(1);
        #1;
        chk({RUN_FORWARD, OPERATOR_STOP_LATCH}, 4'h2, "restart");
        tick(1);
        RUNNING <= 1'h1;
        press_stop(1'h0);
        tick(1);
        want_run <= 1'h0;
        want_rst <= 1'h1;
        tick(8);
        #1;
        chk(OPERATOR_STOP_LATCH, '0, "ext reset");
        tick(1);
        want_rst <= 1'h0;
        RESET_STOP_SELECTION <= 5'h03;
        tick(4);
        press_stop(1'h0);
        chk({OPERATOR_STOP_LATCH, STOP_DECELERATE}, '0, "no latch");
        tick(1);
        PANEL_OPERATION <= 1'h1;
        press_stop(1'h1);
        chk({OPERATOR_STOP_LATCH, STOP_DECELERATE}, 4'h1, "panel stop");
        tick(1);
        RESET_STOP_SELECTION <= 5'h0e;
        PANEL_OPERATION <= 1'h1;
        HANDHELD_PRESENT <= 1'h1;
        tick(3);
        #1;
        chk(HANDHELD_IS_SOURCE, 4'h1, "handheld");
        press_stop(1'h0);
        chk(OPERATOR_STOP_LATCH, 4'h1, "panel latch");
        tick(1);
        RUNNING <= 1'h0;
        STOP_KEY_HANDHELD <= 1'h1;
        tick(1);
        STOP_KEY_HANDHELD <= 1'h0;
        FORWARD_KEY <= 1'h1;
        tick(8);
        #1;
        chk({RUN_FORWARD, OPERATOR_STOP_LATCH}, 4'h2, "panel restart");
        tick(1);
        RUNNING <= 1'h1;
        press_stop(1'h0);
        tick(1);
        RST_N <= 1'h0;
        tick(2);
        RST_N <= 1'h1;
        tick(1);
        #1;
        chk({OPERATOR_STOP_LATCH, WRITE_PERMISSION_SETTING}, '0,
            "power reset");
        conclude();
    end
endmodule
